// File: hdl/adc_cfg_pkg.sv
/*
 * Shared constants for the serial configuration link: frame layout,
 * converter register offsets, field positions, reset values, write
 * masks, the controller's own register map and the link timing.
 * Assumes a 100 MHz core clock on the controller end.
 */
`default_nettype none

package adc_cfg_pkg;

   // ==========================================================
   // frame layout
   localparam int unsigned HDR_BITS   = 8;
   localparam int unsigned DATA_BITS  = 16;
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned ADDR_BITS  = 7;
   localparam logic [4:0]  CNT_HDR    = 5'h08;
   localparam logic [4:0]  CNT_LAST   = 5'h17;
   localparam logic [4:0]  CNT_DONE   = 5'h18;

   // ==========================================================
   // converter registers
   localparam logic [6:0]  REG_WIRING   = 7'h00;
   localparam logic [6:0]  REG_CORR_EN  = 7'h01;
   localparam logic [6:0]  REG_OVR      = 7'h02;
   localparam logic [6:0]  REG_CORR_CTL = 7'h03;

   localparam int unsigned WIRE_MODE_BIT = 15;
   localparam int unsigned DECIM_EN_BIT  = 14;
   localparam int unsigned HIGH_PASS_BIT = 12;
   localparam int unsigned CORR_EN_BIT   = 15;
   localparam int unsigned FORMAT_BIT    = 3;
   localparam int unsigned HP1_BIT       = 1;
   localparam int unsigned OVR_LSB       = 7;
   localparam int unsigned OVR_W         = 4;
   localparam int unsigned ACC_CLR_BIT   = 14;

   localparam logic [15:0] RST_WIRING   = 16'h0000;
   localparam logic [15:0] RST_CORR_EN  = 16'h0000;
   localparam logic [15:0] RST_OVR      = 16'h0780;
   localparam logic [15:0] RST_CORR_CTL = 16'h0b18;
   localparam logic [15:0] RST_OTHER    = 16'h0000;

   localparam logic [15:0] MASK_WIRING   = 16'hd000;
   localparam logic [15:0] MASK_CORR_EN  = 16'h800a;
   localparam logic [15:0] MASK_OVR      = 16'h0780;
   localparam logic [15:0] MASK_CORR_CTL = 16'h4000;
   localparam logic [15:0] MASK_OTHER    = 16'hffff;

   // ==========================================================
   // controller registers (apb, byte addresses)
   localparam logic [7:0]  CTL_CMD    = 8'h00;
   localparam logic [7:0]  CTL_STATUS = 8'h04;
   localparam logic [7:0]  CTL_RDATA  = 8'h08;
   localparam logic [7:0]  CTL_MODE   = 8'h0c;

   localparam int unsigned CMD_RW_BIT       = 23;
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_READY_BIT   = 1;
   localparam int unsigned MODE_FOUR_BIT    = 0;
   localparam int unsigned MODE_RESET_BIT   = 1;

   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned SCLK_MAX_MHZ      = 20;
   localparam int unsigned POWER_ON_MS       = 3;
   localparam int unsigned RESET_PULSE_NS    = 20;
   localparam int unsigned RESET_TO_SEL_NS   = 100;
   localparam int unsigned SEL_SETUP_NS      = 25;

   localparam int unsigned POWER_ON_CYC =
      POWER_ON_MS * 1000000 / CLK_PERIOD_NS;
   // strictly longer than the minimum
   localparam int unsigned RESET_PULSE_CYC =
      RESET_PULSE_NS / CLK_PERIOD_NS + 1;
   localparam int unsigned RESET_TO_SEL_CYC =
      (RESET_TO_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SEL_HOLD_CYC =
      (SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SCLK_HALF_CYC =
      (1000 / (SCLK_MAX_MHZ * CLK_PERIOD_NS) + 1) / 2;

endpackage : adc_cfg_pkg

`default_nettype wire

// File: hdl/serial_link_if.sv
/*
 * The serial configuration link between controller and converter.
 * Assumes an idle-high pull-up on both data wires; each end gives
 * a value and an enable for the shared wire, the device alone for
 * the output wire, and the wire level is resolved here.
 */
`default_nettype none

interface serial_link_if;

   logic serial_clk;
   logic serial_select_n;
   logic hw_reset_n;
   logic data_io_ctl;
   logic data_io_ctl_oe;
   logic data_io_dev;
   logic data_io_dev_oe;
   logic data_io;
   logic serial_data_out_dev;
   logic serial_data_out_oe;
   logic serial_data_out;

   // ==========================================================
   // wire resolution, pulled high when nobody drives
   assign data_io = data_io_dev_oe ? data_io_dev :
                    (data_io_ctl_oe ? data_io_ctl : 1'b1);
   assign serial_data_out = serial_data_out_oe ?
                            serial_data_out_dev : 1'b1;

   modport device (
      input  serial_clk,
      input  serial_select_n,
      input  hw_reset_n,
      input  data_io,
      output data_io_dev,
      output data_io_dev_oe,
      output serial_data_out_dev,
      output serial_data_out_oe
   );

   modport controller (
      output serial_clk,
      output serial_select_n,
      output hw_reset_n,
      output data_io_ctl,
      output data_io_ctl_oe,
      input  data_io,
      input  serial_data_out
   );

endinterface : serial_link_if

`default_nettype wire

// File: hdl/sync_2ff.sv
/*
 * Two-stage level synchroniser.
 * Assumes the input is a level that may change at any time.
 */
`default_nettype none

module sync_2ff (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b1;
         q_o    <= 1'b1;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule : sync_2ff

`default_nettype wire

// File: hdl/adc_serial_config_port.sv
/*
 * Converter end of the serial configuration link: frame decoder,
 * register store and read-back shifter, all clocked by the link clock.
 * Assumes the controller owns the link clock and that the clock
 * stands still between frames; select high and the hardware reset
 * pin act without a clock edge.
 */
`default_nettype none

// What this block does
// - three pins by default, shared data pin
// - 4-pin after write, reads on output pin
// - reg 0x00 bit 15 picks wiring mode
// - 8-bit address word then 16-bit data
// - first rising edge captures read/write flag
// - controller raises select between transfers
// - flag is MSB, then seven address bits
// - write bits latched rising, word stored
// - read shifts D15 first, sampled rising
// - read flag set means no register write
// - link clock at most 20 MHz
// - reset pulse restores all register defaults
// - 3 ms before reset, 100 ns after
// - controller sets correction enable after reset; serial_config_controller leaves it to an APB command
// - accumulator clear set, then cleared starts loop; here loop runs once enabled with clear low
module adc_serial_config_port #(
   parameter int unsigned REG_COUNT = 128
) (
   serial_link_if.device link,
   output logic                  four_pin_mode_o,
   output logic                  decimation_enable_o,
   output logic                  high_pass_o,
   output logic                  interleave_correction_enable_o,
   output logic                  offset_binary_o,
   output logic                  hp_mode1_o,
   output logic [3:0]            overrange_threshold_o,
   output logic                  correction_accumulator_clear_o,
   output logic                  correction_run_o
);

   // ==========================================================
   // register defaults and writable bits
   function automatic logic [15:0] reset_value(
      input logic [6:0] addr
   );
      if (addr == adc_cfg_pkg::REG_WIRING) begin
         return adc_cfg_pkg::RST_WIRING;
      end else if (addr == adc_cfg_pkg::REG_CORR_EN) begin
         return adc_cfg_pkg::RST_CORR_EN;
      end else if (addr == adc_cfg_pkg::REG_OVR) begin
         return adc_cfg_pkg::RST_OVR;
      end else if (addr == adc_cfg_pkg::REG_CORR_CTL) begin
         return adc_cfg_pkg::RST_CORR_CTL;
      end else begin
         return adc_cfg_pkg::RST_OTHER;
      end
   endfunction : reset_value

   // fixed bits keep their default whatever is written
   function automatic logic [15:0] write_mask(
      input logic [6:0] addr
   );
      if (addr == adc_cfg_pkg::REG_WIRING) begin
         return adc_cfg_pkg::MASK_WIRING;
      end else if (addr == adc_cfg_pkg::REG_CORR_EN) begin
         return adc_cfg_pkg::MASK_CORR_EN;
      end else if (addr == adc_cfg_pkg::REG_OVR) begin
         return adc_cfg_pkg::MASK_OVR;
      end else if (addr == adc_cfg_pkg::REG_CORR_CTL) begin
         return adc_cfg_pkg::MASK_CORR_CTL;
      end else begin
         return adc_cfg_pkg::MASK_OTHER;
      end
   endfunction : write_mask

   // ==========================================================
   // frame decoder
   logic [4:0]  bit_cnt_q;
   logic        rw_q;
   logic [6:0]  addr_q;
   logic [15:0] wdata_q;
   logic [15:0] word_d;
   logic        commit;
   logic [15:0] regs_q [REG_COUNT];
   logic [15:0] rd_shift_q;
   logic        rd_active_q;
   logic        four_pin;

   // the link clock stops between frames, so select high must clear
   // the frame state without waiting for an edge
   always_ff @(posedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         bit_cnt_q <= 5'h00;
      end else if (bit_cnt_q != adc_cfg_pkg::CNT_DONE) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         rw_q <= 1'b0;
      end else if (bit_cnt_q == 5'h00) begin
         rw_q <= link.data_io;
      end
   end

   always_ff @(posedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         addr_q <= 7'h00;
      end else if (bit_cnt_q != 5'h00 &&
                   bit_cnt_q < adc_cfg_pkg::CNT_HDR) begin
         addr_q <= {addr_q[5:0], link.data_io};
      end
   end

   always_ff @(posedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         wdata_q <= 16'h0000;
      end else if (bit_cnt_q >= adc_cfg_pkg::CNT_HDR &&
                   bit_cnt_q < adc_cfg_pkg::CNT_DONE) begin
         wdata_q <= {wdata_q[14:0], link.data_io};
      end
   end

   // ==========================================================
   // register store
   // a write lands only on the last data edge of a complete frame
   assign commit = (bit_cnt_q == adc_cfg_pkg::CNT_LAST) &&
                   !rw_q;
   assign word_d = ({wdata_q[14:0], link.data_io} & write_mask(addr_q))
                 | (reset_value(addr_q) & ~write_mask(addr_q));

   always_ff @(posedge link.serial_clk or negedge link.hw_reset_n) begin
      if (!link.hw_reset_n) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_q[i] <= reset_value(7'(i));
         end
      end else if (commit) begin
         regs_q[addr_q] <= word_d;
      end
   end

   // ==========================================================
   // read-back shifter on the falling edge, so each bit is stable
   // for the controller's rising-edge sample
   always_ff @(negedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         rd_shift_q <= 16'h0000;
      end else if (bit_cnt_q == adc_cfg_pkg::CNT_HDR) begin
         rd_shift_q <= regs_q[addr_q];
      end else begin
         rd_shift_q <= {rd_shift_q[14:0], 1'b0};
      end
   end

   always_ff @(negedge link.serial_clk or
               posedge link.serial_select_n) begin
      if (link.serial_select_n) begin
         rd_active_q <= 1'b0;
      end else if (bit_cnt_q == adc_cfg_pkg::CNT_HDR) begin
         rd_active_q <= rw_q;
      end else if (bit_cnt_q == adc_cfg_pkg::CNT_DONE) begin
         rd_active_q <= 1'b0;
      end
   end

   // ==========================================================
   // pin steering
   assign four_pin = regs_q[adc_cfg_pkg::REG_WIRING]
                           [adc_cfg_pkg::WIRE_MODE_BIT];

   // in 4-pin mode the shared pin is input only
   assign link.data_io_dev    = rd_shift_q[15];
   assign link.data_io_dev_oe = rd_active_q && !four_pin;
   assign link.serial_data_out_dev = rd_shift_q[15];
   assign link.serial_data_out_oe  = rd_active_q && four_pin;

   // ==========================================================
   // configuration outputs
   assign four_pin_mode_o     = four_pin;
   assign decimation_enable_o = regs_q[adc_cfg_pkg::REG_WIRING]
                                      [adc_cfg_pkg::DECIM_EN_BIT];
   assign high_pass_o         = regs_q[adc_cfg_pkg::REG_WIRING]
                                      [adc_cfg_pkg::HIGH_PASS_BIT];
   assign interleave_correction_enable_o =
      regs_q[adc_cfg_pkg::REG_CORR_EN][adc_cfg_pkg::CORR_EN_BIT];
   assign offset_binary_o = regs_q[adc_cfg_pkg::REG_CORR_EN]
                                  [adc_cfg_pkg::FORMAT_BIT];
   assign hp_mode1_o      = regs_q[adc_cfg_pkg::REG_CORR_EN]
                                  [adc_cfg_pkg::HP1_BIT];
   assign overrange_threshold_o =
      regs_q[adc_cfg_pkg::REG_OVR]
            [adc_cfg_pkg::OVR_LSB +: adc_cfg_pkg::OVR_W];
   assign correction_accumulator_clear_o =
      regs_q[adc_cfg_pkg::REG_CORR_CTL][adc_cfg_pkg::ACC_CLR_BIT];

   // loop runs while enabled and the clear bit is low, with no set-and-clear pulse needed after reset
   assign correction_run_o = interleave_correction_enable_o &&
                             !correction_accumulator_clear_o;

endmodule : adc_serial_config_port

`default_nettype wire

// File: hdl/serial_config_controller.sv
/*
 * Controller end of the serial configuration link, an APB slave.
 * Brings the converter up (power-on wait, reset pulse, recovery) and
 * runs one 24-bit frame per command. Assumes the 100 MHz core clock;
 * the link clock is divided from it and driven out.
 */
`default_nettype none

module serial_config_controller #(
   parameter int unsigned POWER_ON_CYC = adc_cfg_pkg::POWER_ON_CYC,
   parameter int unsigned HALF_CYC     = adc_cfg_pkg::SCLK_HALF_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   serial_link_if.controller link
);

   typedef enum logic [6:0] {
      ST_POWER   = 7'h01,
      ST_RESET   = 7'h02,
      ST_RECOVER = 7'h04,
      ST_IDLE    = 7'h08,
      ST_LOW     = 7'h10,
      ST_HIGH    = 7'h20,
      ST_TAIL    = 7'h40
   } ctl_state_t;

   ctl_state_t  state_q;
   logic [19:0] wait_q;
   logic [4:0]  bit_q;
   logic [23:0] tx_q;
   logic [15:0] rx_q;
   logic [15:0] rdata_q;
   logic        four_pin_q;
   logic        sclk_q;
   logic        sel_n_q;
   logic        rst_n_q;
   logic        io_sync;
   logic        out_sync;
   logic        wr_acc;
   logic        start;
   logic        reset_req;
   logic        mapped;
   logic        rw_flag_q;

   // ==========================================================
   // apb slave, zero wait states
   assign wr_acc    = psel_i && penable_i && pwrite_i;
   assign start     = wr_acc && paddr_i == adc_cfg_pkg::CTL_CMD &&
                      state_q == ST_IDLE;
   assign reset_req = wr_acc && paddr_i == adc_cfg_pkg::CTL_MODE &&
                      pwdata_i[adc_cfg_pkg::MODE_RESET_BIT] &&
                      state_q == ST_IDLE;
   assign mapped    = paddr_i == adc_cfg_pkg::CTL_CMD ||
                      paddr_i == adc_cfg_pkg::CTL_STATUS ||
                      paddr_i == adc_cfg_pkg::CTL_RDATA ||
                      paddr_i == adc_cfg_pkg::CTL_MODE;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_o <= 32'h0000_0000;
         if (paddr_i == adc_cfg_pkg::CTL_STATUS) begin
            prdata_o[adc_cfg_pkg::STAT_BUSY_BIT]  <= state_q != ST_IDLE;
            prdata_o[adc_cfg_pkg::STAT_READY_BIT] <=
               state_q != ST_POWER && state_q != ST_RESET &&
               state_q != ST_RECOVER;
         end else if (paddr_i == adc_cfg_pkg::CTL_RDATA) begin
            prdata_o[15:0] <= rdata_q;
         end else if (paddr_i == adc_cfg_pkg::CTL_MODE) begin
            prdata_o[adc_cfg_pkg::MODE_FOUR_BIT] <= four_pin_q;
         end
      end
   end

   // software sets this only after a 3-pin write enabled the mode
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         four_pin_q <= 1'b0;
      end else if (wr_acc && paddr_i == adc_cfg_pkg::CTL_MODE) begin
         four_pin_q <= pwdata_i[adc_cfg_pkg::MODE_FOUR_BIT];
      end
   end

   // ==========================================================
   // sequencer
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q <= ST_POWER;
         wait_q  <= 20'(POWER_ON_CYC);
         bit_q   <= 5'h00;
         sclk_q  <= 1'b0;
         sel_n_q <= 1'b1;
         rst_n_q <= 1'b1;
         tx_q    <= 24'h00_0000;
      end else begin
         if (wait_q != 20'h0_0000) begin
            wait_q <= wait_q - 20'h0_0001;
         end
         case (state_q)
            ST_POWER: if (wait_q == 20'h0_0000) begin
               state_q <= ST_RESET;
               rst_n_q <= 1'b0;
               wait_q  <= 20'(adc_cfg_pkg::RESET_PULSE_CYC);
            end
            ST_RESET: if (wait_q == 20'h0_0000) begin
               state_q <= ST_RECOVER;
               rst_n_q <= 1'b1;
               wait_q  <= 20'(adc_cfg_pkg::RESET_TO_SEL_CYC);
            end
            ST_RECOVER: if (wait_q == 20'h0_0000) begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: if (reset_req) begin
               state_q <= ST_RESET;
               rst_n_q <= 1'b0;
               wait_q  <= 20'(adc_cfg_pkg::RESET_PULSE_CYC);
            end else if (start) begin
               state_q <= ST_LOW;
               sel_n_q <= 1'b0;
               bit_q   <= 5'h00;
               tx_q    <= pwdata_i[23:0];
               wait_q  <= 20'(HALF_CYC - 1);
            end
            ST_LOW: if (wait_q == 20'h0_0000) begin
               state_q <= ST_HIGH;
               sclk_q  <= 1'b1;
               wait_q  <= 20'(HALF_CYC - 1);
            end
            ST_HIGH: if (wait_q == 20'h0_0000) begin
               sclk_q <= 1'b0;
               if (bit_q == adc_cfg_pkg::CNT_LAST) begin
                  state_q <= ST_TAIL;
                  wait_q  <= 20'(adc_cfg_pkg::SEL_HOLD_CYC - 1);
               end else begin
                  state_q <= ST_LOW;
                  bit_q   <= bit_q + 5'h01;
                  tx_q    <= {tx_q[22:0], 1'b0};
                  wait_q  <= 20'(HALF_CYC - 1);
               end
            end
            ST_TAIL: if (wait_q == 20'h0_0000) begin
               state_q <= ST_IDLE;
               sel_n_q <= 1'b1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // read capture, on the cycle the link clock rises
   sync_2ff u_io_sync (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .d_i   (link.data_io),
      .q_o   (io_sync)
   );

   sync_2ff u_out_sync (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .d_i   (link.serial_data_out),
      .q_o   (out_sync)
   );

   // sync delay of two cycles fits inside a half period of three
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_q <= 16'h0000;
      end else if (state_q == ST_LOW && wait_q == 20'h0_0000 &&
                   bit_q >= adc_cfg_pkg::CNT_HDR) begin
         rx_q <= {rx_q[14:0], four_pin_q ? out_sync : io_sync};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_q <= 16'h0000;
      end else if (state_q == ST_TAIL && wait_q == 20'h0_0000 &&
                   rw_flag_q) begin
         rdata_q <= rx_q;
      end
   end

   // ==========================================================
   // link pins

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rw_flag_q <= 1'b0;
      end else if (start) begin
         rw_flag_q <= pwdata_i[adc_cfg_pkg::CMD_RW_BIT];
      end
   end

   assign link.serial_clk      = sclk_q;
   assign link.serial_select_n = sel_n_q;
   assign link.hw_reset_n      = rst_n_q;
   assign link.data_io_ctl     = tx_q[23];
   // release the shared pin for the data half of a read
   assign link.data_io_ctl_oe  = (state_q == ST_LOW ||
                                  state_q == ST_HIGH) &&
                                 (bit_q < adc_cfg_pkg::CNT_HDR ||
                                  !rw_flag_q);

endmodule : serial_config_controller

`default_nettype wire

// File: sim/adc_serial_config_port_assertions.sv
/*
 * Checker on the serial configuration link signals.
 * Assumes core clock sampling and rst_i synchronous, active high.
 */
`default_nettype none

module adc_serial_config_port_assertions (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic serial_clk,
   input wire logic serial_select_n,
   input wire logic hw_reset_n,
   input wire logic data_io_ctl_oe,
   input wire logic data_io_dev_oe,
   input wire logic serial_data_out_oe
);
   // ==========================================================
   // link checks; the core clock makes the link clock
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   AST_SHARED_PIN: assert property (
      !(data_io_dev_oe && data_io_ctl_oe)) else $error("pin contention");
   AST_ONE_READ_PIN: assert property (
      !(data_io_dev_oe && serial_data_out_oe)) else $error("two outputs");
   AST_RELEASE_IDLE: assert property (
      serial_select_n |-> !(data_io_dev_oe || serial_data_out_oe))
      else $error("device drives while deselected");
   AST_FRAME_SPAN: assert property (
      $fell(serial_select_n) |-> ##[144:150] serial_select_n)
      else $error("frame length wrong");
   AST_CLK_HALF: assert property (
      $rose(serial_clk) |=> serial_clk [*2] ##1 !serial_clk)
      else $error("link clock too fast");
   AST_CLK_IDLE: assert property (
      serial_select_n |-> !serial_clk) else $error("clock outside frame");
   AST_RESET_PULSE: assert property (
      $fell(hw_reset_n) |=> !hw_reset_n [*3] ##1 hw_reset_n)
      else $error("reset pulse width");
   AST_RESET_TO_SEL: assert property (
      $rose(hw_reset_n) |-> serial_select_n [*8] ##1 serial_select_n [*3])
      else $error("select too soon after reset");
endmodule : adc_serial_config_port_assertions

`default_nettype wire

// File: sim/adc_serial_config_port_tb_top.sv
/*
 * Bench: controller and converter joined by one link, driven over APB.
 * Assumes the package, the link interface and both design ends.
 */
`default_nettype none

module adc_serial_config_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;
   logic        rst_i      = 1'b1;
   logic [7:0]  paddr      = 8'h00;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [31:0] pwdata     = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, err, four, cen, clr, run;
   logic [3:0]  ovr;
   int          n_fail     = 0;
   int          n_compared = 0;
   serial_link_if link ();
   always #5 core_clk_i = ~core_clk_i;
   serial_config_controller #(.POWER_ON_CYC(20))
      serial_config_controller_inst (.core_clk_i(core_clk_i),
      .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .link(link));
   adc_serial_config_port adc_serial_config_port_inst (.link(link),
      .four_pin_mode_o(four), .decimation_enable_o(), .high_pass_o(),
      .interleave_correction_enable_o(cen), .offset_binary_o(),
      .hp_mode1_o(), .overrange_threshold_o(ovr),
      .correction_accumulator_clear_o(clr), .correction_run_o(run));
   adc_serial_config_port_assertions adc_serial_config_port_assertions_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .serial_clk(link.serial_clk), .serial_select_n(link.serial_select_n),
      .hw_reset_n(link.hw_reset_n), .data_io_ctl_oe(link.data_io_ctl_oe),
      .data_io_dev_oe(link.data_io_dev_oe),
      .serial_data_out_oe(link.serial_data_out_oe));

   // ==========================================================
   // access tasks
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do @(posedge core_clk_i); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk
   // poll busy: a command written while busy is dropped silently
   task automatic xfer(input logic rw, input logic [6:0] a,
                       input logic [15:0] d);
      apb(1'b1, adc_cfg_pkg::CTL_CMD, {8'h00, rw, a, d});
      do apb(1'b0, adc_cfg_pkg::CTL_STATUS, 32'h0);
      while (r[0] !== 1'b0);
   endtask : xfer
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      xfer(1'b1, a, 16'hf0f0);
      apb(1'b0, adc_cfg_pkg::CTL_RDATA, 32'h0);
      chk(r[15:0], e);
   endtask : rd
   task automatic wait_ready();
      do apb(1'b0, adc_cfg_pkg::CTL_STATUS, 32'h0); while (r[1] !== 1'b1);
   endtask : wait_ready
   task automatic wrap_up();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // ==========================================================
   // tests
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      wait_ready();
      rd(7'h02, 16'h0780);
      rd(7'h03, 16'h0b18);
      chk({12'h0, ovr}, 16'h000f);
      xfer(1'b0, 7'h05, 16'ha5c3);
      rd(7'h05, 16'ha5c3);
      xfer(1'b1, 7'h05, 16'h1234);
      rd(7'h05, 16'ha5c3);
      xfer(1'b0, 7'h01, 16'h800a);
      chk({15'h0, cen}, 16'h0001);
      xfer(1'b0, 7'h03, 16'h4000);
      chk({14'h0, clr, run}, 16'h0002);
      xfer(1'b0, 7'h03, 16'h0000);
      chk({14'h0, clr, run}, 16'h0001);
      xfer(1'b0, 7'h00, 16'h8000);
      apb(1'b1, adc_cfg_pkg::CTL_MODE, 32'h1);
      rd(7'h05, 16'ha5c3);
      chk({15'h0, four}, 16'h0001);
      apb(1'b1, adc_cfg_pkg::CTL_MODE, 32'h2);
      wait_ready();
      rd(7'h05, 16'h0000);
      chk({15'h0, four}, 16'h0000);
      apb(1'b0, 8'h10, 32'h0);
      chk({15'h0, err}, 16'h0001);
      wrap_up();
   end
   initial begin
      #300us;
      n_fail++;
      wrap_up();
   end
endmodule : adc_serial_config_port_tb_top

`default_nettype wire
